// >>> pkg/ebw_pkg.sv
// Constants and types for the external bus wait, hold and bank block
package ebw_pkg;

  // ****************************************************************
  // Register map (APB byte addresses)
  // ****************************************************************
  localparam logic [7:0] EBW_ADDR_MODE = 8'h00;
  localparam logic [7:0] EBW_ADDR_STAT = 8'h04;
  localparam logic [7:0] EBW_MODE_RST  = 8'h00;

  // Mode register fields
  localparam int EBW_CNT_LSB   = 0;
  localparam int EBW_WMODE_LSB = 2;
  localparam int EBW_BANK_BIT  = 4;
  localparam int EBW_HOLD_BIT  = 5;

  // Status register bits
  localparam int EBW_ST_HOLD   = 0;
  localparam int EBW_ST_EXT    = 1;
  localparam int EBW_ST_PEND   = 2;
  localparam int EBW_ST_BANK   = 3;

  // ****************************************************************
  // Address window exempt from waits (port direction registers)
  // ****************************************************************
  localparam logic [15:0] EBW_DIR_LO = 16'h0008;
  localparam logic [15:0] EBW_DIR_HI = 16'h000F;

  // Phase clock: half period in pclk cycles
  localparam logic [1:0] EBW_PHI_HALF = 2'h1;
  localparam logic [1:0] EBW_CNT_ONE  = 2'h1;
  localparam logic [1:0] EBW_CNT_NONE = 2'h0;

  typedef enum logic [1:0] {
    EBW_WM_OFF  = 2'h0,
    EBW_WM_SOFT = 2'h1,
    EBW_WM_RDY  = 2'h2,
    EBW_WM_XRDY = 2'h3
  } ebw_wmode_t;

  typedef enum logic [1:0] {
    EBW_PM_SINGLE = 2'h0,
    EBW_PM_EXPAND = 2'h1,
    EBW_PM_MICRO  = 2'h2,
    EBW_PM_EPROM  = 2'h3
  } ebw_pmode_t;

  typedef enum logic [3:0] {
    EBW_ST_IDLE_S = 4'b0001,
    EBW_ST_ACC_S  = 4'b0010,
    EBW_ST_EXT_S  = 4'b0100,
    EBW_ST_HLD_S  = 4'b1000
  } ebw_state_t;

endpackage : ebw_pkg

// >>> hdl/ebw_phase_gen.sv
// Phase clock divider giving the bus timing reference and its fall
`timescale 1ns/1ns
module ebw_phase_gen
  import ebw_pkg::*;
(
  input  wire logic pclk,
  input  wire logic presetn,
  output logic      phi_out,
  output logic      phi_fall
);

  logic [1:0] div_r;
  logic       tick;

  // Free running; never stopped, also during bus release
  assign tick     = (div_r == EBW_PHI_HALF - EBW_CNT_ONE);
  assign phi_fall = tick & phi_out;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_r   <= 2'h0;
      phi_out <= 1'b0;
    end else if (tick) begin
      div_r   <= 2'h0;
      phi_out <= ~phi_out;
    end else begin
      div_r   <= div_r + EBW_CNT_ONE;
    end
  end

endmodule : ebw_phase_gen

// >>> hdl/ebw_wait_cnt.sv
// Down counter for extension bus cycles
`timescale 1ns/1ns
module ebw_wait_cnt
  import ebw_pkg::*;
(
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       load,
  input  wire logic [1:0] load_val,
  input  wire logic       dec,
  output logic      [1:0] cnt,
  output logic            last
);

  assign last = (cnt == EBW_CNT_ONE);

  // Load wins over decrement so a restart is never lost
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= EBW_CNT_NONE;
    end else if (load) begin
      cnt <= load_val;
    end else if (dec && cnt != EBW_CNT_NONE) begin
      cnt <= cnt - EBW_CNT_ONE;
    end
  end

endmodule : ebw_wait_cnt

// >>> hdl/ebw_bus_ctrl.sv
// External bus controller: slow memory wait, hold and bank strobe
`timescale 1ns/1ns
module ebw_bus_ctrl
  import ebw_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Core side
  input  wire logic [1:0]  proc_mode,
  input  wire logic        host_flag_sel,
  input  wire logic        acc_req,
  input  wire logic        acc_write,
  input  wire logic        acc_internal,
  input  wire logic        acc_indirect_indexed,
  input  wire logic [15:0] acc_addr,
  input  wire logic [7:0]  acc_wdata,
  output logic      [7:0]  acc_rdata,
  output logic             acc_done,
  output logic             cpu_clk_en,
  // Pins
  output logic      [15:0] addr_o,
  output logic             addr_oe_n,
  output logic      [7:0]  data_o,
  input  wire logic [7:0]  data_i,
  output logic             data_oe_n,
  output logic             rd_n,
  output logic             wr_n,
  output logic             phi_out,
  input  wire logic        ready_i,
  input  wire logic        bus_req_n,
  output logic             bus_grant_n,
  output logic             bank_access_strobe_n
);

  // ****************************************************************
  // Declarations
  // ****************************************************************
  logic [7:0]  cpu_mode_reg_b_r;
  ebw_wmode_t  wmode;
  logic [1:0]  wcnt_cfg;
  logic        expand;
  logic        hold_ok;
  logic        phi_fall;
  ebw_state_t  state_r;
  ebw_state_t  state_nxt;
  logic        start;
  logic        lat_write_r;
  logic        lat_int_r;
  logic        lat_indirect_indexed_r;
  logic [15:0] lat_addr_r;
  logic        wait_ok;
  logic        ext_pend_r;
  logic        first_r;
  logic        cnt_load;
  logic        cnt_dec;
  logic [1:0]  cnt;
  logic        cnt_last;
  logic        restart;
  logic        finish;
  logic        in_ext;
  logic        drive_bus;
  logic        wr_hit;
  logic        map_hit;

  assign wmode    = ebw_wmode_t'(cpu_mode_reg_b_r[EBW_WMODE_LSB +: 2]);
  assign wcnt_cfg = cpu_mode_reg_b_r[EBW_CNT_LSB +: 2];
  assign expand   = (proc_mode == EBW_PM_EXPAND) ||
                    (proc_mode == EBW_PM_MICRO);
  assign hold_ok  = cpu_mode_reg_b_r[EBW_HOLD_BIT] & expand &
                    ~host_flag_sel;

  // ****************************************************************
  // APB slave, zero wait states
  // ****************************************************************
  assign pready  = 1'b1;
  assign map_hit = (paddr == EBW_ADDR_MODE) || (paddr == EBW_ADDR_STAT);
  assign pslverr = psel & penable & ~map_hit;
  assign wr_hit  = psel & penable & pwrite & (paddr == EBW_ADDR_MODE);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cpu_mode_reg_b_r <= EBW_MODE_RST;
    end else if (wr_hit) begin
      cpu_mode_reg_b_r <= pwdata[7:0];
    end
  end

  // Read data captured in setup phase; unmapped reads as zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable) begin
      prdata <= 32'h0000_0000;
      if (paddr == EBW_ADDR_MODE) begin
        prdata[7:0] <= cpu_mode_reg_b_r;
      end else if (paddr == EBW_ADDR_STAT) begin
        prdata[EBW_ST_HOLD] <= (state_r == EBW_ST_HLD_S);
        prdata[EBW_ST_EXT]  <= in_ext;
        prdata[EBW_ST_PEND] <= ext_pend_r;
        prdata[EBW_ST_BANK] <= ~bank_access_strobe_n;
      end
    end
  end

  // ****************************************************************
  // Phase clock and extension counter
  // ****************************************************************
  ebw_phase_gen u_phase (
    .pclk     (pclk),
    .presetn  (presetn),
    .phi_out  (phi_out),
    .phi_fall (phi_fall)
  );

  ebw_wait_cnt u_cnt (
    .pclk     (pclk),
    .presetn  (presetn),
    .load     (cnt_load),
    .load_val (wcnt_cfg),
    .dec      (cnt_dec),
    .cnt      (cnt),
    .last     (cnt_last)
  );

  // ****************************************************************
  // Access sequencing
  // ****************************************************************
  assign in_ext = (state_r == EBW_ST_EXT_S);
  // hold only taken from idle, so a running access completes
  assign start  = (state_r == EBW_ST_IDLE_S) & phi_fall & acc_req &
                  ~(hold_ok & ~bus_req_n);
  assign wait_ok = ~acc_internal & expand & (wmode != EBW_WM_OFF) &
                   (wcnt_cfg != EBW_CNT_NONE) &
                   ~((acc_addr >= EBW_DIR_LO) && (acc_addr <= EBW_DIR_HI));
  // restart while ready low at end of first extension cycle
  assign restart = in_ext & phi_fall & (wmode == EBW_WM_XRDY) &
                   first_r & ~ready_i;
  // count alone ends a plain extension
  assign finish  = phi_fall &
                   (((state_r == EBW_ST_ACC_S) & ~ext_pend_r) |
                    (in_ext & cnt_last & ~restart));
  assign cnt_load = (phi_fall & (state_r == EBW_ST_ACC_S) & ext_pend_r) |
                    restart;
  assign cnt_dec  = in_ext & phi_fall & ~restart;

  // Next state; moves only on phase clock falls
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      EBW_ST_IDLE_S: begin
        if (phi_fall && hold_ok && !bus_req_n) begin
          state_nxt = EBW_ST_HLD_S;
        end else if (start) begin
          state_nxt = EBW_ST_ACC_S;
        end
      end
      EBW_ST_ACC_S: begin
        if (phi_fall) begin
          state_nxt = ext_pend_r ? EBW_ST_EXT_S : EBW_ST_IDLE_S;
        end
      end
      EBW_ST_EXT_S: begin
        if (finish) begin
          state_nxt = EBW_ST_IDLE_S;
        end
      end
      EBW_ST_HLD_S: begin
        // leave on request high or function lost
        if (phi_fall && (bus_req_n || !hold_ok)) begin
          state_nxt = EBW_ST_IDLE_S;
        end
      end
      default: state_nxt = EBW_ST_IDLE_S;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= EBW_ST_IDLE_S;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Latch the access at cycle start
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lat_addr_r  <= 16'h0000;
      lat_write_r <= 1'b0;
      lat_int_r   <= 1'b0;
      lat_indirect_indexed_r  <= 1'b0;
      data_o      <= 8'h00;
    end else if (start) begin
      lat_addr_r  <= acc_addr;
      lat_write_r <= acc_write;
      lat_int_r   <= acc_internal;
      lat_indirect_indexed_r  <= acc_indirect_indexed;
      data_o      <= acc_wdata;
    end
  end

  // Decide extension at cycle start from mode and ready level
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_pend_r <= 1'b0;
    end else if (start) begin
      unique case (wmode)
        EBW_WM_SOFT: ext_pend_r <= wait_ok;
        // ready low before the fall extends
        EBW_WM_RDY,
        EBW_WM_XRDY: ext_pend_r <= wait_ok & ~ready_i;
        EBW_WM_OFF:  ext_pend_r <= 1'b0;
      endcase
    end else if (finish) begin
      ext_pend_r <= 1'b0;
    end
  end

  // First extension cycle marker, set again on each restart
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      first_r <= 1'b0;
    end else if (cnt_load) begin
      first_r <= 1'b1;
    end else if (cnt_dec) begin
      first_r <= 1'b0;
    end
  end

  // Completion pulse and read data
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc_done  <= 1'b0;
      acc_rdata <= 8'h00;
    end else begin
      acc_done <= finish;
      if (finish && !lat_write_r) begin
        acc_rdata <= data_i;
      end
    end
  end

  // ****************************************************************
  // Pin drive
  // ****************************************************************
  // Bus driven in expansion modes unless released
  assign drive_bus = expand & (state_nxt != EBW_ST_HLD_S);

  // float address and data, strobes held high
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      addr_o    <= 16'h0000;
      addr_oe_n <= 1'b1;
      data_oe_n <= 1'b1;
      rd_n      <= 1'b1;
      wr_n      <= 1'b1;
    end else begin
      addr_oe_n <= ~drive_bus;
      if (start) begin
        addr_o <= acc_addr;
      end
      // Strobes only for external cycles, high when idle or released
      // no strobes in single chip, ports keep their own use
      if (state_nxt == EBW_ST_ACC_S || state_nxt == EBW_ST_EXT_S) begin
        rd_n      <= lat_int_nxt() | lat_write_nxt() | ~drive_bus;
        wr_n      <= lat_int_nxt() | ~lat_write_nxt() | ~drive_bus;
        data_oe_n <= lat_int_nxt() | ~lat_write_nxt() | ~drive_bus;
      end else begin
        rd_n      <= 1'b1;
        wr_n      <= 1'b1;
        data_oe_n <= 1'b1;
      end
    end
  end

  // Access attributes as seen in the next cycle
  function automatic logic lat_int_nxt();
    return start ? acc_internal : lat_int_r;
  endfunction : lat_int_nxt

  function automatic logic lat_write_nxt();
    return start ? acc_write : lat_write_r;
  endfunction : lat_write_nxt

  // grant and CPU clock from the release state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bus_grant_n <= 1'b1;
      cpu_clk_en  <= 1'b1;
    end else begin
      bus_grant_n <= ~((state_nxt == EBW_ST_HLD_S) & ~host_flag_sel);
      cpu_clk_en  <= (state_nxt != EBW_ST_HLD_S);
    end
  end

  // bank strobe in indirect indexed data cycles
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bank_access_strobe_n <= 1'b1;
    end else begin
      bank_access_strobe_n <= ~(cpu_mode_reg_b_r[EBW_BANK_BIT] & expand &
        (state_nxt == EBW_ST_ACC_S || state_nxt == EBW_ST_EXT_S) &
        (start ? acc_indirect_indexed : lat_indirect_indexed_r));
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  property p_no_int_wait;
    @(posedge pclk) disable iff (!presetn)
      in_ext |-> !lat_int_r && expand;
  endproperty
  a_no_int_wait: assert property (p_no_int_wait)
    else $error("extension on internal access");

  property p_dir_nowait;
    @(posedge pclk) disable iff (!presetn)
      in_ext |-> !(lat_addr_r >= EBW_DIR_LO && lat_addr_r <= EBW_DIR_HI);
  endproperty
  a_dir_nowait: assert property (p_dir_nowait)
    else $error("wait on direction register access");

  property p_soft_len;
    @(posedge pclk) disable iff (!presetn)
      $rose(in_ext) && wmode == EBW_WM_SOFT && wcnt_cfg == 2'h2
      |-> in_ext [*4] ##1 !in_ext;
  endproperty
  a_soft_len: assert property (p_soft_len)
    else $error("software wait length wrong");

  property p_rdy_skip;
    @(posedge pclk) disable iff (!presetn)
      start && wmode == EBW_WM_RDY && ready_i |=> !ext_pend_r;
  endproperty
  a_rdy_skip: assert property (p_rdy_skip)
    else $error("ready high still extended");

  property p_rdy_fixed;
    @(posedge pclk) disable iff (!presetn)
      cnt_dec && wmode == EBW_WM_RDY && !cnt_last
      |=> in_ext && cnt == $past(cnt) - 2'h1;
  endproperty
  a_rdy_fixed: assert property (p_rdy_fixed)
    else $error("ready wait count not fixed");

  property p_xrdy_restart;
    @(posedge pclk) disable iff (!presetn)
      in_ext && phi_fall && wmode == EBW_WM_XRDY && first_r && !ready_i
      |=> in_ext && cnt == wcnt_cfg && first_r;
  endproperty
  a_xrdy_restart: assert property (p_xrdy_restart)
    else $error("extended ready did not restart");

  property p_release_pins;
    @(posedge pclk) disable iff (!presetn)
      !bus_grant_n |-> addr_oe_n && data_oe_n && rd_n && wr_n &&
                       !cpu_clk_en;
  endproperty
  a_release_pins: assert property (p_release_pins)
    else $error("bus driven while granted");

  property p_phi_runs;
    @(posedge pclk) disable iff (!presetn)
      !bus_grant_n ##1 !bus_grant_n |-> phi_out != $past(phi_out, 1) ||
                                        phi_out != $past(phi_out, 2);
  endproperty
  a_phi_runs: assert property (p_phi_runs)
    else $error("phase clock stopped in release");

  property p_grant_ok;
    @(posedge pclk) disable iff (!presetn)
      !bus_grant_n |-> cpu_mode_reg_b_r[EBW_HOLD_BIT] && expand &&
                       !host_flag_sel;
  endproperty
  a_grant_ok: assert property (p_grant_ok)
    else $error("grant without hold enable");

  property p_give_back;
    @(posedge pclk) disable iff (!presetn)
      state_r == EBW_ST_HLD_S && phi_fall && bus_req_n
      |=> bus_grant_n && !addr_oe_n;
  endproperty
  a_give_back: assert property (p_give_back)
    else $error("buses not regained");

  property p_bank_ok;
    @(posedge pclk) disable iff (!presetn)
      !bank_access_strobe_n |-> cpu_mode_reg_b_r[EBW_BANK_BIT] && expand;
  endproperty
  a_bank_ok: assert property (p_bank_ok)
    else $error("bank strobe without enable");

  c_soft: cover property (@(posedge pclk) disable iff (!presetn)
    $rose(in_ext) && wmode == EBW_WM_SOFT);
  c_restart: cover property (@(posedge pclk) disable iff (!presetn)
    restart);
  c_hold: cover property (@(posedge pclk) disable iff (!presetn)
    $fell(bus_grant_n));
  c_bank: cover property (@(posedge pclk) disable iff (!presetn)
    $fell(bank_access_strobe_n));

endmodule : ebw_bus_ctrl

// >>> verif/ebw_ext_mem.sv
// Far side model: external memory with a bank decoder and a ready source
`timescale 1ns/1ns
module ebw_ext_mem
  import ebw_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic [15:0] addr_o,
  input  wire logic        addr_oe_n,
  input  wire logic [7:0]  data_o,
  input  wire logic        data_oe_n,
  input  wire logic        rd_n,
  input  wire logic        wr_n,
  input  wire logic        bank_access_strobe_n,
  input  wire logic [3:0]  slow,
  output logic      [7:0]  data_i,
  output logic             ready_i
);
  // ****************************************************************
  // Storage and decode
  // ****************************************************************
  logic [7:0] mem_r [32];
  logic [7:0] last_r;
  logic [3:0] low_r;
  logic [4:0] idx;

  // Preload with the index so reads are predictable
  initial begin
    last_r = 8'h5A;
    low_r  = 4'h0;
    for (int i = 0; i < 32; i++) begin
      mem_r[i] = 8'(i);
    end
  end

  assign idx = {~bank_access_strobe_n, addr_o[3:0]};
  // Idle bus shows the inverse of the last value, never a stale copy
  assign data_i = (!rd_n && !addr_oe_n) ? mem_r[idx] : ~last_r;
  assign ready_i = (slow == 4'h0) || (!(rd_n && wr_n) && low_r >= slow);

  // Count strobe cycles; a slow part answers late
  always @(posedge pclk) begin
    last_r <= data_i;
    low_r  <= (rd_n && wr_n) ? 4'h0 : low_r + 4'(low_r != 4'hF);
    if (!wr_n && !data_oe_n) begin
      mem_r[idx] <= data_o;
    end
  end
endmodule : ebw_ext_mem

// >>> verif/tb_external_bus_wait_hold_bank.sv
// Self-checking bench for the external bus wait, hold and bank block
`timescale 1ns/1ns
module tb_external_bus_wait_hold_bank
  import ebw_pkg::*;
;
  // ****************************************************************
  // Signals and instances
  // ****************************************************************
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic        host_flag_sel = 0, acc_req = 0, acc_write = 0;
  logic        acc_internal = 0, acc_indirect_indexed = 0, bus_req_n = 1;
  logic [1:0]  proc_mode = 2'h1;
  logic [7:0]  paddr = 8'h00, acc_wdata = 8'h00, acc_rdata, data_o, data_i;
  logic [31:0] pwdata = 32'h0, prdata;
  logic [15:0] acc_addr = 16'h0, addr_o;
  logic [3:0]  slow = 4'h0;
  logic        pready, pslverr, acc_done, cpu_clk_en, addr_oe_n, data_oe_n;
  logic        rd_n, wr_n, phi_out, ready_i, bus_grant_n;
  logic        bank_access_strobe_n;
  int          error_cnt = 0, checks_done = 0, cyc = 0;

  ebw_bus_ctrl DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .proc_mode, .host_flag_sel,
    .acc_req, .acc_write, .acc_internal, .acc_indirect_indexed, .acc_addr, .acc_wdata,
    .acc_rdata, .acc_done, .cpu_clk_en, .addr_o, .addr_oe_n, .data_o,
    .data_i, .data_oe_n, .rd_n, .wr_n, .phi_out, .ready_i, .bus_req_n,
    .bus_grant_n, .bank_access_strobe_n);

  ebw_ext_mem u_mem (.pclk, .addr_o, .addr_oe_n, .data_o, .data_oe_n,
    .rd_n, .wr_n, .bank_access_strobe_n, .slow, .data_i, .ready_i);

  always #5 pclk = ~pclk;

  // Hang guard well above the few hundred cycles the tests need
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      complete_run;
    end
  end

  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task automatic cmp(input logic [31:0] got, exp, input string what);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask : cmp

  task automatic complete_run;
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : complete_run

  // Setup cycle, then access phase held until pready
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] r,
                     output logic e);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic setmode(input logic h, b, input ebw_wmode_t wm,
                         input logic [1:0] c);
    logic [31:0] r;
    logic        e;
    apb(1'b1, EBW_ADDR_MODE, {26'h0, h, b, wm, c}, r, e);
  endtask : setmode

  // Request launched just after a phase fall; held until done is seen
  task automatic acc(input logic w, intl, indirect_indexed, input logic [15:0] a,
                     input logic [7:0] d, input logic hreq,
                     output int wid, output logic bk, output logic [7:0] rd);
    int   n;
    wid  = 0;
    bk   = 0;
    n    = 0;
    @(posedge pclk iff phi_out === 1'b1);
    acc_req      <= 1'b1;
    acc_write    <= w;
    acc_internal <= intl;
    acc_indirect_indexed     <= indirect_indexed;
    acc_addr     <= a;
    acc_wdata    <= d;
    repeat (2) @(posedge pclk);
    while (acc_done !== 1'b1 && n < 200) begin
      @(posedge pclk);
      n++;
      if (!(rd_n && wr_n)) begin
        wid++;
        cmp(32'({addr_oe_n, addr_o}), 32'(a), "address");
        if (hreq) begin
          bus_req_n <= 1'b0;
          cmp(32'(bus_grant_n), 32'h1, "grant during access");
        end
      end
      if (bank_access_strobe_n === 1'b0) begin
        bk = 1;
      end
    end
    // Released only after the done pulse, so no second take can occur
    acc_req <= 1'b0;
    cmp(32'(acc_done), 32'h1, "access done");
    rd = acc_rdata;
  endtask : acc

  task automatic one(input ebw_pmode_t pm, input ebw_wmode_t wm,
                     input logic [1:0] c, input logic [3:0] s,
                     input logic [15:0] a, input logic intl, input int exp);
    int         wid;
    logic       bk;
    logic [7:0] rd;
    proc_mode <= pm;
    slow      <= s;
    setmode(1'b0, 1'b0, wm, c);
    acc(1'b0, intl, 1'b0, a, 8'h00, 1'b0, wid, bk, rd);
    cmp(32'(wid), 32'(exp), "strobe width");
    if (!intl) begin
      cmp(32'(rd), 32'(a[3:0]), "read data");
    end
  endtask : one

  task automatic wait_grant(input logic v);
    int n;
    n = 0;
    while (bus_grant_n !== v && n < 20) begin
      @(posedge pclk);
      n++;
    end
    cmp(32'(bus_grant_n), 32'(v), "grant level");
  endtask : wait_grant

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_regs;
    logic [31:0] r;
    logic        e;
    apb(1'b0, EBW_ADDR_MODE, 32'h0, r, e);
    cmp(r, 32'(EBW_MODE_RST), "mode reset");
    apb(1'b1, EBW_ADDR_MODE, 32'h0000003F, r, e);
    apb(1'b0, EBW_ADDR_MODE, 32'h0, r, e);
    cmp(r, 32'h0000003F, "mode readback");
    apb(1'b0, 8'h10, 32'h0, r, e);
    cmp({r[30:0], e}, 32'h1, "unmapped read");
    apb(1'b1, EBW_ADDR_STAT, 32'h0000000F, r, e);
    cmp(32'(e), 32'h0, "status write");
    $display("test regs done");
  endtask : t_regs

  task automatic t_waits;
    int         wid;
    logic       bk;
    logic [7:0] rd;
    one(EBW_PM_EXPAND, EBW_WM_SOFT, 2'h1, 4'h5, 16'h1234, 1'b0, 4);
    one(EBW_PM_MICRO, EBW_WM_SOFT, 2'h3, 4'h0, 16'h2005, 1'b0, 8);
    one(EBW_PM_EXPAND, EBW_WM_SOFT, 2'h2, 4'h0, 16'h3006, 1'b0, 6);
    one(EBW_PM_EXPAND, EBW_WM_SOFT, 2'h0, 4'h0, 16'h3007, 1'b0, 2);
    one(EBW_PM_EXPAND, EBW_WM_RDY, 2'h2, 4'h0, 16'h4009, 1'b0, 2);
    one(EBW_PM_EXPAND, EBW_WM_RDY, 2'h2, 4'h1, 16'h400A, 1'b0, 6);
    one(EBW_PM_EXPAND, EBW_WM_SOFT, 2'h3, 4'h0, 16'h0008, 1'b0, 2);
    one(EBW_PM_MICRO, EBW_WM_SOFT, 2'h3, 4'h0, 16'h000F, 1'b0, 2);
    one(EBW_PM_EXPAND, EBW_WM_OFF, 2'h3, 4'h3, 16'h500B, 1'b0, 2);
    one(EBW_PM_EXPAND, EBW_WM_SOFT, 2'h3, 4'h0, 16'h600C, 1'b1, 0);
    one(EBW_PM_EXPAND, EBW_WM_XRDY, 2'h1, 4'h0, 16'h700D, 1'b0, 2);
    // Ready held low long enough to force two restarts
    slow <= 4'h7;
    setmode(1'b0, 1'b0, EBW_WM_XRDY, 2'h1);
    acc(1'b0, 1'b0, 1'b0, 16'h700E, 8'h00, 1'b0, wid, bk, rd);
    cmp(32'(wid >= 7 && wid <= 13 && wid % 2 == 0), 32'h1, "xrdy");
    $display("test waits done");
  endtask : t_waits

  task automatic t_bank;
    int         wid;
    logic       bk;
    logic [7:0] rd;
    slow      <= 4'h0;
    proc_mode <= EBW_PM_EXPAND;
    setmode(1'b0, 1'b1, EBW_WM_OFF, 2'h0);
    acc(1'b1, 1'b0, 1'b1, 16'h8003, 8'hC3, 1'b0, wid, bk, rd);
    cmp(32'(bk), 32'h1, "bank strobe on");
    acc(1'b0, 1'b0, 1'b0, 16'h8003, 8'h00, 1'b0, wid, bk, rd);
    cmp({bk, rd}, 32'h003, "plain read");
    acc(1'b0, 1'b0, 1'b1, 16'h8003, 8'h00, 1'b0, wid, bk, rd);
    cmp({bk, rd}, 32'h1C3, "bank read");
    setmode(1'b0, 1'b0, EBW_WM_OFF, 2'h0);
    acc(1'b0, 1'b0, 1'b1, 16'h8004, 8'h00, 1'b0, wid, bk, rd);
    cmp(32'(bk), 32'h0, "bank disabled");
    proc_mode <= EBW_PM_SINGLE;
    setmode(1'b0, 1'b1, EBW_WM_SOFT, 2'h3);
    acc(1'b0, 1'b0, 1'b1, 16'h8005, 8'h00, 1'b0, wid, bk, rd);
    cmp(32'(bk), 32'h0, "single chip bank");
    cmp(32'(wid), 32'h0, "single chip strobes");
    $display("test bank done");
  endtask : t_bank

  task automatic t_hold;
    int          wid;
    logic        bk, p;
    logic [7:0]  rd;
    logic [31:0] r;
    logic        e;
    proc_mode <= EBW_PM_EXPAND;
    setmode(1'b1, 1'b0, EBW_WM_SOFT, 2'h1);
    acc(1'b1, 1'b0, 1'b0, 16'h9001, 8'h11, 1'b1, wid, bk, rd);
    wait_grant(1'b0);
    cmp({addr_oe_n, data_oe_n, rd_n, wr_n, cpu_clk_en}, 32'h1E, "released");
    p = phi_out;
    @(posedge pclk);
    cmp(32'(phi_out != p), 32'h1, "phase runs");
    apb(1'b0, EBW_ADDR_STAT, 32'h0, r, e);
    cmp(32'(r[EBW_ST_HOLD]), 32'h1, "status released");
    bus_req_n <= 1'b1;
    wait_grant(1'b1);
    cmp({addr_oe_n, cpu_clk_en}, 32'h1, "regained");
    setmode(1'b0, 1'b0, EBW_WM_SOFT, 2'h1);
    bus_req_n <= 1'b0;
    repeat (6) @(posedge pclk);
    cmp(32'(bus_grant_n), 32'h1, "hold disabled");
    host_flag_sel <= 1'b1;
    setmode(1'b1, 1'b0, EBW_WM_SOFT, 2'h1);
    repeat (6) @(posedge pclk);
    cmp(32'(bus_grant_n), 32'h1, "pin as flag");
    host_flag_sel <= 1'b0;
    proc_mode     <= EBW_PM_SINGLE;
    repeat (6) @(posedge pclk);
    cmp(32'(bus_grant_n), 32'h1, "single chip hold");
    bus_req_n <= 1'b1;
    $display("test hold done");
  endtask : t_hold

  // Main sequence
  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    t_regs;
    t_waits;
    t_bank;
    t_hold;
    complete_run;
  end
endmodule : tb_external_bus_wait_hold_bank
